//--- rtl/dsm_mapper.sv
// DS3 to envelope mapper: sends one envelope per frame period.
// Assumes the DS3 source flags a filling elastic store on i_fill_high.
`timescale 1ns/1ps
`default_nettype none
module dsm_mapper #(
    parameter int FRAME_CYC = dsm_pkg::FRAME_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Envelope link
    dsm_spe_if.mapper spe,
    // DS3 source
    input wire logic i_ds3_valid,
    input wire logic i_ds3_bit,
    output logic o_ds3_ready,
    input wire logic i_fill_high,
    // Path overhead byte source
    input wire logic [7:0] i_poh_byte,
    output logic o_poh_ready,
    // Overhead channel
    input wire logic i_ohc_en,
    input wire logic i_ohc_bit,
    output logic o_ohc_ready,
    // Status
    output logic o_busy,
    output logic o_underrun,
    output logic o_opp_stuff,
    output logic o_opp_data
);
    import dsm_pkg::*;

    typedef enum logic {
        MS_IDLE,
        MS_SEND
    } dsm_mst_t;

    localparam logic [14:0] FRM_LAST = 15'(FRAME_CYC - 1);

    dsm_mst_t state_q;
    logic [14:0] frm_q;
    logic [3:0] row_q;
    logic [6:0] col_q;
    logic [2:0] bit_q;
    logic stuff_q;
    logic [7:0] poh_q;
    logic frm_tick;
    logic sending;
    logic end_bit;
    logic end_col;
    logic end_row;
    logic row_start;
    logic env_start;
    logic take_ds3;
    logic take_ohc;
    logic nb;
    dsm_bk_t kind;

    assign sending = (state_q == MS_SEND);
    assign frm_tick = (frm_q == FRM_LAST);
    assign end_bit = (bit_q == LAST_BIT);
    assign end_col = (col_q == LAST_COL);
    assign end_row = (row_q == LAST_ROW);
    assign row_start = sending && (col_q == COL_POH) && (bit_q == 3'h0);
    assign env_start = row_start && (row_q == 4'h0);
    assign kind = dsm_bit_kind(col_q, bit_q);

    // Data positions pull one DS3 bit each
    assign take_ds3 = sending && (kind == DSM_BK_DATA ||
                                  (kind == DSM_BK_OPP && !stuff_q));
    assign take_ohc = sending && (kind == DSM_BK_OHC) && i_ohc_en;

    assign o_ds3_ready = take_ds3;
    assign o_ohc_ready = take_ohc;
    assign o_poh_ready = row_start;
    assign o_busy = sending;

    // Frame period timer, free running
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            frm_q <= 15'h0000;
        end else if (frm_tick) begin
            frm_q <= 15'h0000;
        end else begin
            frm_q <= frm_q + 15'h0001;
        end
    end

    // Envelope sequencing; a tick during a send is dropped
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_q <= MS_IDLE;
        end else begin
            case (state_q)
                MS_IDLE: begin
                    if (frm_tick) begin
                        state_q <= MS_SEND;
                    end
                end
                MS_SEND: begin
                    if (end_bit && end_col && end_row) begin
                        state_q <= MS_IDLE;
                    end
                end
                default: begin
                    state_q <= MS_IDLE;
                end
            endcase
        end
    end

    // Bit, column and row counters
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bit_q <= 3'h0;
            col_q <= 7'h00;
            row_q <= 4'h0;
        end else if (!sending) begin
            bit_q <= 3'h0;
            col_q <= 7'h00;
            row_q <= 4'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            if (end_bit) begin
                if (end_col) begin
                    col_q <= 7'h00;
                    row_q <= end_row ? 4'h0 : row_q + 4'h1;
                end else begin
                    col_q <= col_q + 7'h01;
                end
            end
        end
    end

    // Stuff decision per row, taken before its control bits go out
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stuff_q <= 1'b1;
        end else if (row_start) begin
            stuff_q <= !i_fill_high;
        end
    end

    // Path overhead byte captured at row start; its bit 7 goes out in that same bit, the rest from the next bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            poh_q <= 8'h00;
        end else if (row_start) begin
            poh_q <= {i_poh_byte[6:0], 1'b0};
        end else if (sending && kind == DSM_BK_POH) begin
            poh_q <= {poh_q[6:0], 1'b0};
        end
    end

    // Value of the bit now being sent
    always_comb begin
        nb = 1'b0;
        case (kind)
            DSM_BK_DATA: begin
                nb = i_ds3_valid & i_ds3_bit;
            end
            DSM_BK_OPP: begin
                nb = !stuff_q & i_ds3_valid & i_ds3_bit;
            end
            DSM_BK_CTL: begin
                nb = stuff_q;
            end
            DSM_BK_OHC: begin
                nb = i_ohc_en & i_ohc_bit;
            end
            DSM_BK_POH: begin
                nb = row_start ? i_poh_byte[7] : poh_q[7];
            end
            default: begin
                nb = 1'b0;
            end
        endcase
    end

    // Link outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            spe.spe_valid <= 1'b0;
            spe.spe_sof <= 1'b0;
            spe.spe_bit <= 1'b0;
        end else begin
            spe.spe_valid <= sending;
            spe.spe_sof <= env_start;
            spe.spe_bit <= sending & nb;
        end
    end

    // Status pulses
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_underrun <= 1'b0;
            o_opp_stuff <= 1'b0;
            o_opp_data <= 1'b0;
        end else begin
            o_underrun <= take_ds3 && !i_ds3_valid;
            o_opp_stuff <= sending && kind == DSM_BK_OPP && stuff_q;
            o_opp_data <= sending && kind == DSM_BK_OPP && !stuff_q;
        end
    end

endmodule : dsm_mapper
`default_nettype wire

//--- rtl/dsm_pkg.sv
// Shared constants and bit-kind lookup for the envelope mapper pair.
// Assumes one clock for both ends; the link carries one envelope bit per cycle.
package dsm_pkg;

    // Envelope grid
    localparam logic [6:0] LAST_COL = 7'h56;
    localparam logic [3:0] LAST_ROW = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Column positions
    localparam logic [6:0] COL_POH = 7'h00;
    localparam logic [6:0] COL_C1 = 7'h03;
    localparam logic [6:0] COL_C2 = 7'h1f;
    localparam logic [6:0] COL_C3 = 7'h3c;
    localparam logic [6:0] FIX_LEAD = 7'h02;

    // Bit masks inside the control bytes, bit 7 sent first
    localparam logic [7:0] C1_CTL = 8'h20;
    localparam logic [7:0] C1_DATA = 8'h1f;
    localparam logic [7:0] C2_CTL = 8'hc0;
    localparam logic [7:0] C3_CTL = 8'hc0;
    localparam logic [7:0] C3_OHC = 8'h0c;
    localparam logic [7:0] C3_OPP = 8'h01;

    // Control vote
    localparam logic [2:0] CTL_BITS = 3'h5;
    localparam logic [2:0] CTL_MAJ = 3'h3;

    // Frame timing
    localparam int CLK_NS = 4;
    localparam int FRAME_RATE_HZ = 8000;
    localparam int FRAME_NS = 1000000000 / FRAME_RATE_HZ;
    localparam int FRAME_CYC = FRAME_NS / CLK_NS;

    typedef enum logic [2:0] {
        DSM_BK_POH,
        DSM_BK_FIX,
        DSM_BK_CTL,
        DSM_BK_DATA,
        DSM_BK_OHC,
        DSM_BK_OPP
    } dsm_bk_t;

    // Kind of the bit at a column and bit index (0 = first sent)
    function automatic dsm_bk_t dsm_bit_kind(input logic [6:0] col,
                                             input logic [2:0] idx);
        logic [2:0] p;
        dsm_bk_t k;
        p = LAST_BIT - idx;
        k = DSM_BK_DATA;
        if (col == COL_POH) begin
            k = DSM_BK_POH;
        end else if (col == COL_C1) begin
            k = C1_CTL[p] ? DSM_BK_CTL : (C1_DATA[p] ? DSM_BK_DATA : DSM_BK_FIX);
        end else if (col == COL_C2) begin
            k = C2_CTL[p] ? DSM_BK_CTL : DSM_BK_FIX;
        end else if (col == COL_C3) begin
            if (C3_CTL[p]) begin
                k = DSM_BK_CTL;
            end else if (C3_OHC[p]) begin
                k = DSM_BK_OHC;
            end else if (C3_OPP[p]) begin
                k = DSM_BK_OPP;
            end else begin
                k = DSM_BK_FIX;
            end
        end else if (col < COL_C1 || (col >= COL_C2 - FIX_LEAD && col < COL_C2) ||
                     (col >= COL_C3 - FIX_LEAD && col < COL_C3)) begin
            k = DSM_BK_FIX;
        end
        return k;
    endfunction : dsm_bit_kind

endpackage : dsm_pkg

//--- rtl/dsm_spe_if.sv
// Serial envelope link between mapper and de-mapper.
// Assumes both ends sit on the same clock; one bit per valid cycle.
`timescale 1ns/1ps
`default_nettype none
interface dsm_spe_if;
    logic spe_valid;
    logic spe_sof;
    logic spe_bit;

    modport mapper (
        output spe_valid,
        output spe_sof,
        output spe_bit
    );

    modport demapper (
        input spe_valid,
        input spe_sof,
        input spe_bit
    );
endinterface : dsm_spe_if
`default_nettype wire

//--- rtl/dsm_demapper.sv
// Envelope to DS3 de-mapper: recovers data and overhead-channel bits.
// Assumes the link marks each envelope's first bit with spe_sof.
`timescale 1ns/1ps
`default_nettype none
module dsm_demapper (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Envelope link
    dsm_spe_if.demapper spe,
    // Recovered DS3
    output logic o_ds3_valid,
    output logic o_ds3_bit,
    // Overhead channel
    output logic o_ohc_valid,
    output logic o_ohc_bit,
    // Status
    output logic o_sync,
    output logic o_opp_stuff,
    output logic o_ctl_split
);
    import dsm_pkg::*;

    logic sync_q;
    logic [3:0] row_q;
    logic [6:0] col_q;
    logic [2:0] bit_q;
    logic [2:0] ones_q;
    logic act;
    logic [6:0] col_c;
    logic [2:0] bit_c;
    logic [3:0] row_c;
    logic last;
    logic stuff;
    dsm_bk_t kind;

    // A start marker forces the position to the envelope origin
    assign act = spe.spe_valid && (sync_q || spe.spe_sof);
    assign col_c = spe.spe_sof ? COL_POH : col_q;
    assign bit_c = spe.spe_sof ? 3'h0 : bit_q;
    assign row_c = spe.spe_sof ? 4'h0 : row_q;
    assign last = (bit_c == LAST_BIT) && (col_c == LAST_COL) && (row_c == LAST_ROW);
    assign kind = dsm_bit_kind(col_c, bit_c);
    assign stuff = (ones_q >= CTL_MAJ);
    assign o_sync = sync_q;

    // Alignment: held from a start marker to the envelope's last bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sync_q <= 1'b0;
        end else if (act) begin
            sync_q <= !last;
        end
    end

    // Position counters
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bit_q <= 3'h0;
            col_q <= 7'h00;
            row_q <= 4'h0;
        end else if (act) begin
            bit_q <= bit_c + 3'h1;
            col_q <= col_c;
            row_q <= row_c;
            if (bit_c == LAST_BIT) begin
                if (col_c == LAST_COL) begin
                    col_q <= 7'h00;
                    row_q <= (row_c == LAST_ROW) ? 4'h0 : row_c + 4'h1;
                end else begin
                    col_q <= col_c + 7'h01;
                end
            end
        end
    end

    // Count of control bits set in the current row
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ones_q <= 3'h0;
        end else if (act && col_c == COL_POH && bit_c == 3'h0) begin
            ones_q <= 3'h0;
        end else if (act && kind == DSM_BK_CTL && spe.spe_bit) begin
            ones_q <= ones_q + 3'h1;
        end
    end

    // Recovered outputs; fixed stuff and path overhead are dropped
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ds3_valid <= 1'b0;
            o_ds3_bit <= 1'b0;
            o_ohc_valid <= 1'b0;
            o_ohc_bit <= 1'b0;
        end else begin
            o_ds3_valid <= act && (kind == DSM_BK_DATA ||
                                   (kind == DSM_BK_OPP && !stuff));
            o_ds3_bit <= spe.spe_bit;
            o_ohc_valid <= act && kind == DSM_BK_OHC;
            o_ohc_bit <= spe.spe_bit;
        end
    end

    // Per-row stuff and disagreement pulses at the opportunity bit
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_opp_stuff <= 1'b0;
            o_ctl_split <= 1'b0;
        end else begin
            o_opp_stuff <= act && kind == DSM_BK_OPP && stuff;
            o_ctl_split <= act && kind == DSM_BK_OPP &&
                           ones_q != 3'h0 && ones_q != CTL_BITS;
        end
    end

endmodule : dsm_demapper
`default_nettype wire

//--- test/dsm_spe_chk.sv
// Checker for the serial envelope link between mapper and de-mapper.
// Assumes it sits beside the link instance with the mapper's frame period.
`timescale 1ns/1ps
`default_nettype none
module dsm_spe_chk #(
    parameter int FRAME_CYC = dsm_pkg::FRAME_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Link
    input wire logic spe_valid,
    input wire logic spe_sof,
    input wire logic spe_bit
);
    import dsm_pkg::*;
    logic [12:0] cnt_q;
    logic act_q;
    logic ctl_q;
    logic seen_q;
    int gap_q;
    logic [12:0] pos;
    logic [6:0] col;
    logic [2:0] idx;
    logic opp;
    logic ctl_more;
    logic fix;
    assign pos = spe_sof ? 13'h0 : cnt_q;
    assign col = 7'((pos >> 3) % 87);
    assign idx = pos[2:0];
    assign opp = act_q && col == COL_C3 && idx == 3'h7;
    assign ctl_more = (col == COL_C2 || col == COL_C3) && idx < 3'h2;
    assign fix = col inside {7'h01, 7'h02, 7'h1d, 7'h1e, 7'h3a, 7'h3b} ||
                 (col == COL_C1 && idx < 3'h2) || (col == COL_C2 && idx > 3'h1) ||
                 (col == COL_C3 && idx inside {3'h2, 3'h3, 3'h6});

    // Bit position inside the envelope
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_q <= 13'h0;
            act_q <= 1'b0;
        end else if (spe_valid && (spe_sof || act_q)) begin
            cnt_q <= pos + 13'h1;
            act_q <= pos != 13'h1877;
        end
    end

    // First control bit of the row
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctl_q <= 1'b0;
        end else if (spe_valid && (spe_sof || act_q) && col == COL_C1 && idx == 3'h2) begin
            ctl_q <= spe_bit;
        end
    end

    // Cycles since the last envelope start
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= spe_sof ? 1 : gap_q + 1;
            seen_q <= seen_q | spe_sof;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_sof_has_valid: assert property (spe_sof |-> spe_valid)
        else $error("start marker without valid");
    a_env_unbroken: assert property (act_q |-> spe_valid)
        else $error("gap inside envelope");
    a_env_ends: assert property (act_q && pos == 13'h1877 |=> !spe_valid [*8])
        else $error("envelope longer than grid");
    a_stray_valid: assert property (spe_valid && !act_q |-> spe_sof)
        else $error("valid bit outside envelope");
    a_no_early_sof: assert property (act_q |-> !spe_sof)
        else $error("start marker inside envelope");
    a_ctl_unanimous: assert property (act_q && ctl_more |-> spe_bit == ctl_q)
        else $error("control bits of row disagree");
    a_fix_zero: assert property (act_q && fix |-> !spe_bit)
        else $error("fixed stuff bit not zero");
    a_opp_stuff_zero: assert property (opp && ctl_q |-> !spe_bit)
        else $error("stuffed opportunity bit not zero");
    a_frame_period: assert property (spe_sof && seen_q |-> gap_q == FRAME_CYC)
        else $error("envelope period wrong");

    c_env: cover property (spe_sof);
    c_stuff_row: cover property (opp && ctl_q);
    c_data_row: cover property (opp && !ctl_q);
endmodule : dsm_spe_chk
`default_nettype wire

//--- test/tb_ds3_sts1_spe_bit_mapper.sv
// Bench for the mapper and de-mapper pair joined by the envelope link.
// Assumes one 250 MHz clock; a second de-mapper takes a hand-made link.
`timescale 1ns/1ps
`default_nettype none
module tb_ds3_sts1_spe_bit_mapper;
    import dsm_pkg::*;
    localparam int FRAME = 6400;
    localparam logic [15:0] FILL = 16'hb38d;
    // Control bits per row of the hand-made envelope, row 0 lowest
    localparam logic [44:0] CTL_TAB = {5'h1f, 5'h01, 5'h1e, 5'h08, 5'h15, 5'h00, 5'h1f,
                                       5'h03, 5'h1c};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ds3_valid, ds3_bit, fill_high, ohc_en, ohc_bit, drop;
    logic [7:0] poh_byte, wsr, poh_last, poh_exp;
    logic ds3_ready, poh_ready, ohc_ready, busy, underrun, m_stuff, m_data;
    logic d_valid, d_bit, h_valid, h_bit, sync, d_stuff, split;
    logic x_valid, x_bit, x_stuff, x_split;
    logic [15:0] s;
    logic exp_q[$];
    logic ohc_q[$];
    int n_mismatch = 0;
    int comparisons = 0;
    int n_push, n_und_exp, n_und, n_stuff_exp, n_mstuff, n_mdata, n_dstuff, n_split;
    int n_x, n_xone, n_xstuff, n_xsplit, wpos, fi;

    dsm_spe_if spe();
    dsm_spe_if spe2();
    dsm_mapper #(.FRAME_CYC(FRAME)) dsm_mapper_i (.i_clk(clk), .i_rst_b(rst_b), .spe(spe),
        .i_ds3_valid(ds3_valid), .i_ds3_bit(ds3_bit), .o_ds3_ready(ds3_ready),
        .i_fill_high(fill_high), .i_poh_byte(poh_byte), .o_poh_ready(poh_ready),
        .i_ohc_en(ohc_en), .i_ohc_bit(ohc_bit), .o_ohc_ready(ohc_ready), .o_busy(busy),
        .o_underrun(underrun), .o_opp_stuff(m_stuff), .o_opp_data(m_data));
    dsm_demapper dsm_demapper_i (.i_clk(clk), .i_rst_b(rst_b), .spe(spe),
        .o_ds3_valid(d_valid), .o_ds3_bit(d_bit), .o_ohc_valid(h_valid), .o_ohc_bit(h_bit),
        .o_sync(sync), .o_opp_stuff(d_stuff), .o_ctl_split(split));
    dsm_demapper fault_dsm_demapper_i (.i_clk(clk), .i_rst_b(rst_b), .spe(spe2),
        .o_ds3_valid(x_valid), .o_ds3_bit(x_bit), .o_ohc_valid(), .o_ohc_bit(),
        .o_sync(), .o_opp_stuff(x_stuff), .o_ctl_split(x_split));
    dsm_spe_chk #(.FRAME_CYC(FRAME)) dsm_spe_chk_i (.i_clk(clk), .i_rst_b(rst_b),
        .spe_valid(spe.spe_valid), .spe_sof(spe.spe_sof), .spe_bit(spe.spe_bit));

    always #2 clk = ~clk;

    always @(posedge clk) begin
        s <= s + 16'h1;
        ds3_bit <= s[0] ^ s[2];
        ohc_bit <= s[1];
        ds3_valid <= !(drop && s[3:0] == 4'h5);
        if (poh_ready) begin
            poh_byte <= poh_byte + 8'h3b;
            fill_high <= FILL[fi % 16];
            fi = fi + 1;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        if (ds3_ready) begin
            exp_q.push_back(ds3_valid & ds3_bit);
            n_push++;
            n_und_exp += !ds3_valid;
        end
        if (ohc_ready) ohc_q.push_back(ohc_bit);
        if (poh_ready) poh_last = poh_byte;
        n_stuff_exp += poh_ready && !fill_high;
        n_und += underrun;
        n_mstuff += m_stuff;
        n_mdata += m_data;
        n_dstuff += d_stuff;
        n_split += split;
        n_x += x_valid;
        n_xone += x_valid && x_bit;
        n_xstuff += x_stuff;
        n_xsplit += x_split;
        if (d_valid) check("ds3 bit", d_bit, exp_q.size() ? exp_q.pop_front() : 1'bx);
        if (h_valid) check("ohc bit", h_bit, ohc_q.size() ? ohc_q.pop_front() : 1'b0);
        if (spe.spe_valid && !spe.spe_sof) check("sync busy", sync, 1'b1);
        if (spe.spe_valid) begin
            if (spe.spe_sof) begin
                if (wpos != 0) check("envelope bits", wpos, 6264);
                wpos = 0;
                poh_exp = poh_last;
            end
            wsr = {wsr[6:0], spe.spe_bit};
            wpos++;
            if (wpos == 8) check("poh byte", wsr, poh_exp);
        end
    end

    task automatic wait_env();
        int t;
        bit seen;
        seen = 0;
        for (t = 0; t < 20000; t++) begin
            @(posedge clk);
            if (busy === 1'b1) seen = 1;
            if (seen && busy === 1'b0) return;
        end
        n_mismatch++;
        conclude();
    endtask : wait_env

    // Hand-made envelope, preceded by valid bits without a start marker
    task automatic send_fault();
        int p, c, i, r, k;
        for (p = -16; p < 6264; p++) begin
            c = p < 0 ? 0 : (p / 8) % 87;
            i = p < 0 ? 0 : p % 8;
            r = p < 0 ? 0 : p / 696;
            k = (c == 3 && i == 2) ? 0 : (c == 31 && i < 2) ? 1 + i : (c == 60 && i < 2) ? 3 + i : 9;
            @(posedge clk);
            spe2.spe_valid <= 1'b1;
            spe2.spe_sof <= p == 0;
            spe2.spe_bit <= p < 0 ? 1'b1 : k < 5 ? CTL_TAB[r * 5 + 4 - k] : c == 60 && i == 7;
        end
        @(posedge clk);
        spe2.spe_valid <= 1'b0;
        spe2.spe_sof <= 1'b0;
        spe2.spe_bit <= 1'b1;
    endtask : send_fault

    initial begin
        {ds3_valid, ds3_bit, fill_high, ohc_en, ohc_bit, drop} = '0;
        {spe2.spe_valid, spe2.spe_sof, spe2.spe_bit} = '0;
        poh_byte = 8'h5a;
        s = '0;
        {n_push, n_und_exp, n_und, n_stuff_exp, n_mstuff, n_mdata, n_dstuff, n_split} = '0;
        {n_x, n_xone, n_xstuff, n_xsplit, wpos, fi} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        wait_env();
        // Last link bit lands in the de-mapper one edge after busy falls
        @(posedge clk);
        check("sync idle", sync, 1'b0);
        ohc_en <= 1'b1;
        wait_env();
        drop <= 1'b1;
        wait_env();
        repeat (4) @(posedge clk);
        check("ds3 slots", n_push, 3 * 5589 + 27 - n_stuff_exp);
        check("ds3 left", exp_q.size(), 0);
        check("ohc left", ohc_q.size(), 0);
        check("underruns", n_und, n_und_exp);
        check("map stuff", n_mstuff, n_stuff_exp);
        check("map data", n_mdata, 27 - n_stuff_exp);
        check("demap stuff", n_dstuff, n_stuff_exp);
        check("split", n_split, 0);
        check("envelope bits", wpos, 6264);
        send_fault();
        repeat (4) @(posedge clk);
        check("vote count", n_x, 5589 + 4);
        check("vote ones", n_xone, 4);
        check("vote stuff", n_xstuff, 5);
        check("vote split", n_xsplit, 6);
        conclude();
    end
endmodule : tb_ds3_sts1_spe_bit_mapper
`default_nettype wire
